// >>> logic/edp_pkg.sv
package edp_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int RAM_WORDS = 1024;
   localparam logic [DATA_W-1:0] RAM_INIT = 16'h0000;
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;

   // Pin group coming from the master
   typedef struct packed {
      logic hold_request_n;
      logic ram_access_request_n;
      logic access_strobe_n;
      logic read_not_write;
   } edp_ctl_t;

   typedef enum logic [3:0] {
      ST_RUN = 4'h1,
      ST_HOLD = 4'h2,
      ST_RAM = 4'h4,
      ST_XFER = 4'h8
   } edp_state_t;
endpackage

// >>> logic/edp_port.sv
`timescale 1ns/1ps
// Operation
// - On granting hold the device floats its bus lines and asserts hold acknowledge.
// - The device asserts RAM access acknowledge for a low request only while hold ack is low.
// - With strobe, RAM ack and hold ack low, the access runs for as long as strobe is low.
// - With hold ack and RAM request low, the address pins are inputs selecting the RAM word.
// - Access to external local memory uses hold request and acknowledge alone.
module edp_port #(
   parameter int WORDS = edp_pkg::RAM_WORDS
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic clock_en,
   input wire edp_pkg::edp_ctl_t ctl_pins,
   input wire logic [edp_pkg::ADDR_W-1:0] address_pins_in,
   input wire logic [edp_pkg::DATA_W-1:0] data_pins_in,
   input wire logic core_bus_addr_oe,
   input wire logic core_bus_data_oe,
   output logic bus_takeover_ack_n,
   output logic ram_access_ack_n,
   output logic address_pins_oe,
   output logic [edp_pkg::DATA_W-1:0] data_pins_out,
   output logic data_pins_oe,
   output logic core_halted
);
   import edp_pkg::*;

   localparam int IDX_W = $clog2(WORDS);

   edp_ctl_t ctl_meta, ctl_sync;
   logic [ADDR_W-1:0] addr_meta, addr_sync;
   logic [DATA_W-1:0] data_meta, data_sync;
   edp_state_t state, next_state;
   logic next_hold_ack_n, next_ram_ack_n, next_addr_oe, next_data_oe, next_halted;
   logic [DATA_W-1:0] next_data_out;
   logic [DATA_W-1:0] ram [WORDS];
   logic ram_we;
   logic [IDX_W-1:0] ram_idx;

   // Two-stage synchronisers for every pin input
   always_ff @(posedge clock) begin
      if (srst) begin
         ctl_meta <= '1;
         ctl_sync <= '1;
         addr_meta <= ADDR_RST;
         addr_sync <= ADDR_RST;
         data_meta <= DATA_RST;
         data_sync <= DATA_RST;
      end else if (clock_en) begin
         ctl_meta <= ctl_pins;
         ctl_sync <= ctl_meta;
         addr_meta <= address_pins_in;
         addr_sync <= addr_meta;
         data_meta <= data_pins_in;
         data_sync <= data_meta;
      end
   end

   assign ram_idx = addr_sync[IDX_W-1:0];

   always_comb begin
      next_state = state;
      next_hold_ack_n = bus_takeover_ack_n;
      next_ram_ack_n = ram_access_ack_n;
      next_addr_oe = address_pins_oe;
      next_data_oe = 1'b0;
      next_data_out = data_pins_out;
      next_halted = core_halted;
      ram_we = 1'b0;
      unique case (state)
         ST_RUN: begin
            next_addr_oe = core_bus_addr_oe;
            next_data_oe = core_bus_data_oe;
            if (!ctl_sync.hold_request_n) begin
               next_state = ST_HOLD;
               next_hold_ack_n = 1'b0;
               next_addr_oe = 1'b0;
               next_data_oe = 1'b0;
               next_halted = 1'b1;
            end
         end
         ST_HOLD: begin
            if (ctl_sync.hold_request_n) begin
               next_state = ST_RUN;
               next_hold_ack_n = 1'b1;
               next_halted = 1'b0;
            end else if (!ctl_sync.ram_access_request_n) begin
               next_state = ST_RAM;
               next_ram_ack_n = 1'b0;
            end
         end
         ST_RAM: begin
            if (ctl_sync.ram_access_request_n) begin
               next_state = ST_HOLD;
               next_ram_ack_n = 1'b1;
            end else if (!ctl_sync.access_strobe_n) begin
               next_state = ST_XFER;
            end
         end
         ST_XFER: begin
            if (ctl_sync.read_not_write) begin
               next_data_oe = !ctl_sync.access_strobe_n;
               next_data_out = ram[ram_idx];
            end else if (!ctl_sync.access_strobe_n) begin
               ram_we = 1'b1;
            end
            if (ctl_sync.access_strobe_n) begin
               next_state = ST_RAM;
               next_data_oe = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state <= ST_RUN;
         bus_takeover_ack_n <= 1'b1;
         ram_access_ack_n <= 1'b1;
         address_pins_oe <= 1'b0;
         data_pins_oe <= 1'b0;
         data_pins_out <= DATA_RST;
         core_halted <= 1'b0;
      end else if (clock_en) begin
         state <= next_state;
         bus_takeover_ack_n <= next_hold_ack_n;
         ram_access_ack_n <= next_ram_ack_n;
         address_pins_oe <= next_addr_oe;
         data_pins_oe <= next_data_oe;
         data_pins_out <= next_data_out;
         core_halted <= next_halted;
      end
   end

   // Write happens every strobe-low cycle in ST_XFER with read_not_write low; the last value held wins
   always_ff @(posedge clock) begin
      if (clock_en && ram_we) begin
         ram[ram_idx] <= data_sync;
      end
   end

   ram_ack_needs_hold_a: assert property (@(posedge clock) disable iff (srst)
      !ram_access_ack_n |-> !bus_takeover_ack_n)
      else $error("ram ack low without hold ack");

   hold_grant_a: assert property (@(posedge clock) disable iff (srst)
      (clock_en && state == ST_RUN && !ctl_sync.hold_request_n)
      |=> (!bus_takeover_ack_n && !address_pins_oe && !data_pins_oe))
      else $error("hold not granted with floated bus");

   ram_grant_a: assert property (@(posedge clock) disable iff (srst)
      (clock_en && state == ST_HOLD && !ctl_sync.hold_request_n
       && !ctl_sync.ram_access_request_n) |=> !ram_access_ack_n)
      else $error("ram request not acknowledged");

   read_drive_a: assert property (@(posedge clock) disable iff (srst)
      data_pins_oe && bus_takeover_ack_n == 1'b0 |-> !ram_access_ack_n)
      else $error("data driven in hold outside ram access");

   bus_floated_a: assert property (@(posedge clock) disable iff (srst)
      !bus_takeover_ack_n |-> !address_pins_oe)
      else $error("address driven during hold");

   release_order_a: assert property (@(posedge clock) disable iff (srst)
      $rose(bus_takeover_ack_n) |-> ram_access_ack_n && $past(ram_access_ack_n))
      else $error("hold ack released before ram ack");

   strobe_end_a: assert property (@(posedge clock) disable iff (srst)
      (clock_en && state == ST_XFER && ctl_sync.access_strobe_n) |=> !data_pins_oe)
      else $error("data still driven after strobe end");

   resume_a: assert property (@(posedge clock) disable iff (srst)
      (clock_en && state == ST_HOLD && ctl_sync.hold_request_n)
      |=> (bus_takeover_ack_n && !core_halted))
      else $error("device did not resume after hold release");

   // Checks on the hold, RAM access and data paths
   xfer_acks_low_a: assert property (@(posedge clock) disable iff (srst)
      state == ST_XFER
      |-> (!ram_access_ack_n && !bus_takeover_ack_n))
      else $error("ram transfer without both acknowledges");

   halt_tracks_hold_a: assert property (@(posedge clock) disable iff (srst)
      core_halted
      |-> !bus_takeover_ack_n)
      else $error("core halted outside hold");

   hold_kept_a: assert property (@(posedge clock) disable iff (srst)
      (clock_en && state == ST_RAM && ctl_sync.hold_request_n)
      |=> !bus_takeover_ack_n)
      else $error("hold released while ram ack low");

   ram_release_a: assert property (@(posedge clock) disable iff (srst)
      (clock_en && state == ST_RAM && ctl_sync.ram_access_request_n)
      |=> (ram_access_ack_n && !bus_takeover_ack_n))
      else $error("ram ack not released in order");

   read_data_a: assert property (@(posedge clock) disable iff (srst)
      (clock_en && state == ST_XFER && ctl_sync.read_not_write && !ctl_sync.access_strobe_n)
      |=> (data_pins_oe && data_pins_out == $past(ram[ram_idx])))
      else $error("read word not driven");

   write_no_drive_a: assert property (@(posedge clock) disable iff (srst)
      (clock_en && state == ST_XFER && !ctl_sync.read_not_write)
      |=> !data_pins_oe)
      else $error("data driven during ram write");

   no_early_ram_a: assert property (@(posedge clock) disable iff (srst)
      (clock_en && state == ST_RUN)
      |=> ram_access_ack_n)
      else $error("ram ack without hold");

   core_bus_a: assert property (@(posedge clock) disable iff (srst)
      (clock_en && state == ST_RUN && ctl_sync.hold_request_n)
      |=> (address_pins_oe == $past(core_bus_addr_oe)
           && data_pins_oe == $past(core_bus_data_oe)))
      else $error("bus lines not retaken by core");
endmodule // edp_port

// >>> sim/edp_master.sv
`timescale 1ns/1ps
module edp_master (
   input wire logic clock,
   input wire logic [edp_pkg::DATA_W-1:0] dev_data,
   input wire logic dev_oe,
   output edp_pkg::edp_ctl_t ctl,
   output logic [edp_pkg::ADDR_W-1:0] addr,
   output logic [edp_pkg::DATA_W-1:0] bus
);
   import edp_pkg::*;
   logic drive = 1'b0;
   logic [DATA_W-1:0] wdata = 16'h0000;
   logic [DATA_W-1:0] last = 16'h0000;
   initial ctl = 4'hF;
   initial addr = 16'h0000;
   // Nobody drives: the bus flips every cycle
   always_comb bus = dev_oe ? dev_data : (drive ? wdata : ~last);
   always @(posedge clock) last <= bus;
   task automatic pins(input logic h, input logic r, input int n);
      @(negedge clock);
      ctl.hold_request_n = h;
      ctl.ram_access_request_n = r;
      repeat (n) @(negedge clock);
   endtask
   task automatic access(input logic rnw, input logic [15:0] a, input logic [15:0] d);
      @(negedge clock);
      drive = ~rnw;
      wdata = d;
      addr = a;
      ctl.read_not_write = rnw;
      ctl.access_strobe_n = 1'b0;
      repeat (4) @(negedge clock);
   endtask
   task automatic finish_access;
      @(negedge clock);
      ctl.access_strobe_n = 1'b1;
      repeat (4) @(negedge clock);
      drive = 1'b0;
   endtask
endmodule // edp_master

// >>> sim/tb_external_dma_ram_access_port.sv
`timescale 1ns/1ps
module tb_external_dma_ram_access_port;
   import edp_pkg::*;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic core_oe = 1'b1;
   edp_ctl_t ctl;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] bus;
   logic [DATA_W-1:0] dout;
   logic hack_n, rack_n, addr_oe, dout_oe, halted;
   logic [15:0] wa [3] = '{16'h0000, 16'h000F, 16'h0005};
   logic [15:0] wd [3] = '{16'hA5C3, 16'h0FF0, 16'h5A3C};
   int mismatches = 0;
   int n_checks = 0;
   initial forever #2.5 clock = ~clock;
   edp_port #(.WORDS(16)) i_edp_port (.clock(clock), .srst(srst), .clock_en(1'b1),
      .ctl_pins(ctl), .address_pins_in(addr), .data_pins_in(bus),
      .core_bus_addr_oe(core_oe), .core_bus_data_oe(core_oe), .bus_takeover_ack_n(hack_n),
      .ram_access_ack_n(rack_n), .address_pins_oe(addr_oe), .data_pins_out(dout),
      .data_pins_oe(dout_oe), .core_halted(halted));
   edp_master i_edp_master (.clock(clock), .dev_data(dout), .dev_oe(dout_oe), .ctl(ctl),
      .addr(addr), .bus(bus));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic t_local;
      i_edp_master.pins(1'b0, 1'b1, 3);
      check({hack_n, addr_oe, halted}, 3'b001);
      i_edp_master.pins(1'b0, 1'b1, 6);
      check(rack_n, 1'b1);
      i_edp_master.pins(1'b1, 1'b1, 4);
      check({hack_n, addr_oe, halted}, 3'b110);
      $display("Test local hold done");
   endtask
   task automatic t_grant;
      i_edp_master.pins(1'b1, 1'b0, 6);
      check(rack_n, 1'b1);
      i_edp_master.pins(1'b0, 1'b0, 2);
      check(rack_n, 1'b1);
      i_edp_master.pins(1'b0, 1'b0, 4);
      check({hack_n, rack_n}, 2'b00);
      $display("Test grant done");
   endtask
   task automatic t_xfer;
      for (int i = 0; i < 3; i++) begin
         i_edp_master.access(1'b0, wa[i], wd[i]);
         check(dout_oe, 1'b0);
         i_edp_master.finish_access();
      end
      for (int i = 2; i >= 0; i--) begin
         i_edp_master.access(1'b1, wa[i], 16'h0000);
         check({dout_oe, dout}, {1'b1, wd[i]});
         i_edp_master.finish_access();
         check(dout_oe, 1'b0);
      end
      $display("Test transfers done");
   endtask
   task automatic t_release;
      i_edp_master.pins(1'b1, 1'b0, 5);
      check(hack_n, 1'b0);
      i_edp_master.pins(1'b1, 1'b1, 3);
      check(rack_n, 1'b1);
      i_edp_master.pins(1'b1, 1'b1, 4);
      check({hack_n, halted, addr_oe}, 3'b101);
      $display("Test release done");
   endtask
   task automatic close_out;
      $display("Checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(negedge clock);
      srst = 1'b0;
      t_local();
      t_grant();
      t_xfer();
      t_release();
      close_out();
   end
   initial begin
      #20000;
      mismatches++;
      close_out();
   end
endmodule // tb_external_dma_ram_access_port
